// ---- rtl/uoy_regs.svh ----
// Purpose: offsets, field positions, reset values for the OUT endpoint Y-buffer descriptors
// Assumes: byte address = 4 * register index, endpoint slots 8 indexes apart
// Notes:   Summary of operation below
// Summary of operation
// [RL1] Y-buffer start address is field bits 10..3 with three zero low bits.
// [RL2] Firmware writes each endpoint's Y-buffer base before any transfer uses it.
// [RL3] Buffer manager starts every transaction at the base; base never changed by hardware.
// [RL4] Byte count field is plain binary 0..64, 1000000b meaning 64 bytes.
// [RL5] Firmware never writes a count above 64; larger values are undefined.
// [RL6] Handshake flag clear means buffer empty and ready for host OUT data.
// [RL7] Handshake flag set means valid packet held; further host OUT gets NAK.
// [RL8] Size field gives shared X/Y capacity up to 64; bit 7 reserved zero.
// [RL9] On packet stored, length and flag are written together in one cycle.
`ifndef UOY_REGS_SVH
`define UOY_REGS_SVH
`define UOY_OFF_Y_BASE    3'h5
`define UOY_OFF_Y_COUNT   3'h6
`define UOY_OFF_XY_SIZE   3'h7
`define UOY_EP_SLOTS      2'h3
`define UOY_FLAG_BIT      7
`define UOY_BASE_LSBS     3'h0
`define UOY_RST_BASE      8'h00
`define UOY_RST_COUNT     7'h00
`define UOY_RST_SIZE      7'h00
`define UOY_RST_FLAG      1'b0
`endif

// ---- rtl/uoy_pkg.sv ----
// Purpose: shared types for the OUT endpoint Y-buffer descriptor bank
// Assumes: nothing beyond the constants header
// Notes:   register codes follow the order of the printed offsets
package uoy_pkg;
	typedef logic [6:0] uoy_count_type;
	typedef logic [1:0] uoy_slot_type;
	typedef enum logic [1:0] {
		UOY_REG_BASE  = 2'b00,
		UOY_REG_COUNT = 2'b01,
		UOY_REG_SIZE  = 2'b10
	} uoy_reg_type;
endpackage : uoy_pkg

// ---- rtl/uoy_top.sv ----
// Purpose: Y-buffer descriptor registers for OUT endpoints 1..3 with buffer manager port
// Assumes: buffer manager signals are on clk; bus is Avalon-MM with waitrequest
// Notes:   every bus access answers on the second cycle of the request
`include "uoy_regs.svh"
module uoy_top (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// avalon-mm slave
	input  wire logic [6:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// buffer manager request: host OUT token for an endpoint
	input  wire logic              bm_req,
	input  wire logic [1:0]        bm_req_ep,
	output logic                   bm_resp,
	output logic                   bm_nak,
	output logic      [10:0]       bm_start_addr,
	output logic      [6:0]        bm_buf_size,
	// buffer manager completion: packet stored in the Y-buffer
	input  wire logic              bm_done,
	input  wire logic [1:0]        bm_done_ep,
	input  wire uoy_pkg::uoy_count_type bm_done_len
);
	import uoy_pkg::*;

	logic [7:0]    base_q [3];
	logic [7:0]    base_d [3];
	uoy_count_type cnt_q  [3];
	uoy_count_type cnt_d  [3];
	logic          flag_q [3];
	logic          flag_d [3];
	uoy_count_type size_q [3];
	uoy_count_type size_d [3];
	logic          wait_q, wait_d;
	logic [31:0]   rdata_q, rdata_d;
	logic          resp_q, resp_d, nak_q, nak_d;
	logic [10:0]   addr_q, addr_d;
	uoy_count_type bsize_q, bsize_d;

	// returns {hit, slot, register code}
	function automatic logic [4:0] uoy_decode(input logic [6:0] a);
		logic [2:0] off;
		logic       hit;
		off = a[4:2];
		hit = (a[1:0] == 2'h0) && (a[6:5] < `UOY_EP_SLOTS) && (off >= `UOY_OFF_Y_BASE);
		return {hit, a[6:5], 2'(off - `UOY_OFF_Y_BASE)};
	endfunction : uoy_decode

	// endpoints 1..3 map to slots 0..2; endpoint 0 is not served here
	function automatic logic [2:0] uoy_ep_slot(input logic [1:0] ep);
		return {ep != 2'h0, 2'(ep - 2'h1)};
	endfunction : uoy_ep_slot

	logic [4:0]   dec;
	logic [2:0]   req_s, done_s;
	logic         wr_fire, rd_start;

	assign dec      = uoy_decode(avs_address);
	assign req_s    = uoy_ep_slot(bm_req_ep);
	assign done_s   = uoy_ep_slot(bm_done_ep);
	assign wr_fire  = avs_write && !wait_q && avs_byteenable[0] && dec[4];
	assign rd_start = avs_read && wait_q;

	always_comb begin
		wait_d  = !((avs_read || avs_write) && wait_q);
		rdata_d = rdata_q;
		if (rd_start) begin
			rdata_d = 32'h0;
			if (dec[4]) begin
				unique case (uoy_reg_type'(dec[1:0]))
					UOY_REG_BASE:  rdata_d[7:0] = base_q[dec[3:2]];
					UOY_REG_COUNT: rdata_d[7:0] = {flag_q[dec[3:2]], cnt_q[dec[3:2]]};
					// [RL8] reserved bit 7 reads zero
					UOY_REG_SIZE:  rdata_d[7:0] = {1'b0, size_q[dec[3:2]]};
					default:       rdata_d = 32'h0;
				endcase
			end
		end
		for (int i = 0; i < 3; i++) begin
			base_d[i] = base_q[i];
			cnt_d[i]  = cnt_q[i];
			flag_d[i] = flag_q[i];
			size_d[i] = size_q[i];
			if (wr_fire && dec[3:2] == 2'(i)) begin
				unique case (uoy_reg_type'(dec[1:0]))
					UOY_REG_BASE: base_d[i] = avs_writedata[7:0];
					// [RL4] plain binary count, flag in bit 7
					UOY_REG_COUNT: begin
						cnt_d[i]  = avs_writedata[6:0];
						flag_d[i] = avs_writedata[`UOY_FLAG_BIT];
					end
					UOY_REG_SIZE: size_d[i] = avs_writedata[6:0];
					default: ;
				endcase
			end
			// [RL9] length and flag together
			// hardware completion overrides a same-cycle firmware write so no packet is lost
			if (bm_done && done_s[2] && done_s[1:0] == 2'(i)) begin
				cnt_d[i]  = bm_done_len;
				flag_d[i] = 1'b1;
			end
		end
	end

	always_comb begin
		resp_d  = bm_req && req_s[2];
		nak_d   = nak_q;
		addr_d  = addr_q;
		bsize_d = bsize_q;
		if (resp_d) begin
			// [RL6] [RL7] flag decides accept or nak
			nak_d   = flag_q[req_s[1:0]];
			// [RL1] [RL3] start address from base
			addr_d  = {base_q[req_s[1:0]], `UOY_BASE_LSBS};
			// [RL8] shared buffer capacity
			bsize_d = size_q[req_s[1:0]];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
			resp_q  <= 1'b0;
			nak_q   <= 1'b0;
			addr_q  <= 11'h000;
			bsize_q <= `UOY_RST_SIZE;
			for (int i = 0; i < 3; i++) begin
				base_q[i] <= `UOY_RST_BASE;
				cnt_q[i]  <= `UOY_RST_COUNT;
				flag_q[i] <= `UOY_RST_FLAG;
				size_q[i] <= `UOY_RST_SIZE;
			end
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
			resp_q  <= resp_d;
			nak_q   <= nak_d;
			addr_q  <= addr_d;
			bsize_q <= bsize_d;
			for (int i = 0; i < 3; i++) begin
				base_q[i] <= base_d[i];
				cnt_q[i]  <= cnt_d[i];
				flag_q[i] <= flag_d[i];
				size_q[i] <= size_d[i];
			end
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign bm_resp         = resp_q;
	assign bm_nak          = nak_q;
	assign bm_start_addr   = addr_q;
	assign bm_buf_size     = bsize_q;

	// helpers read only by the checks below
	logic [7:0]    req_base, req_flag_w;
	uoy_count_type req_size;
	logic [23:0]   base_flat;
	logic [1:0]    chk_slot_q;
	uoy_count_type chk_len_q;
	logic          done_ok;
	assign req_base   = base_q[req_s[1:0]];
	assign req_size   = size_q[req_s[1:0]];
	assign req_flag_w = {7'h00, flag_q[req_s[1:0]]};
	assign base_flat  = {base_q[2], base_q[1], base_q[0]};
	assign done_ok    = bm_done && done_s[2];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_slot_q <= 2'h0;
			chk_len_q  <= 7'h00;
		end else begin
			chk_slot_q <= done_s[1:0];
			chk_len_q  <= bm_done_len;
		end
	end

	property p_start_addr;
		@(posedge clk) disable iff (!rst_n)
		(bm_req && req_s[2]) |=> (bm_start_addr == {$past(req_base), 3'h0}) && bm_resp;
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start address not base with zero lsbs"); // [RL1]

	property p_base_kept;
		@(posedge clk) disable iff (!rst_n)
		(done_ok && !wr_fire) |=> $stable(base_flat);
	endproperty
	a_base_kept: assert property (p_base_kept) else $error("base changed by packet completion"); // [RL3]

	property p_count_len;
		@(posedge clk) disable iff (!rst_n)
		done_ok |=> cnt_q[chk_slot_q] == chk_len_q;
	endproperty
	a_count_len: assert property (p_count_len) else $error("count not loaded with packet length"); // [RL4]

	property p_accept;
		@(posedge clk) disable iff (!rst_n)
		(bm_req && req_s[2] && req_flag_w == 8'h00) |=> bm_resp && !bm_nak;
	endproperty
	a_accept: assert property (p_accept) else $error("empty buffer refused host out"); // [RL6]

	property p_nak;
		@(posedge clk) disable iff (!rst_n)
		(bm_req && req_s[2] && req_flag_w != 8'h00) |=> bm_resp && bm_nak;
	endproperty
	a_nak: assert property (p_nak) else $error("full buffer did not nak"); // [RL7]

	property p_size;
		@(posedge clk) disable iff (!rst_n)
		(bm_req && req_s[2]) |=> bm_buf_size == $past(req_size);
	endproperty
	a_size: assert property (p_size) else $error("buffer size mismatch"); // [RL8]

	property p_flag_set;
		@(posedge clk) disable iff (!rst_n)
		done_ok |=> flag_q[chk_slot_q] && (cnt_q[chk_slot_q] == chk_len_q);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set with count"); // [RL9]

	property p_wait_one;
		@(posedge clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
endmodule : uoy_top

// ---- sim/uoy_bm_model.sv ----
// Purpose: buffer manager stand-in raising host OUT tokens and packet stores
// Assumes: uoy_top answers a token one cycle after it is taken
// Notes:   released lines show the inverse so stale values are not trusted
module uoy_bm_model (
	// clock and answer
	input  wire logic              clk,
	input  wire logic              bm_resp,
	// requests
	output logic                   bm_req,
	output logic [1:0]             bm_req_ep,
	output logic                   bm_done,
	output logic [1:0]             bm_done_ep,
	output uoy_pkg::uoy_count_type bm_done_len
);
	import uoy_pkg::*;
	initial begin
		{bm_req, bm_req_ep, bm_done, bm_done_ep, bm_done_len} = '0;
	end
	task token(input logic [1:0] ep, output logic seen);
		@(posedge clk);
		bm_req <= 1'b1;
		bm_req_ep <= ep;
		@(posedge clk);
		bm_req <= 1'b0;
		bm_req_ep <= ~ep;
		// the answer stands for the one cycle after the taking edge
		@(posedge clk);
		seen = bm_resp;
	endtask : token
	task store(input logic [1:0] ep, input uoy_count_type len);
		@(posedge clk);
		bm_done <= 1'b1;
		bm_done_ep <= ep;
		bm_done_len <= len;
		@(posedge clk);
		bm_done <= 1'b0;
		bm_done_ep <= ~ep;
		bm_done_len <= ~len;
	endtask : store
endmodule : uoy_bm_model

// ---- sim/uoy_top_tb.sv ----
// Purpose: self-checking bench for the OUT endpoint Y-buffer descriptors
// Assumes: bus accesses wait on waitrequest, answer one cycle after a token
// Notes:   table rows write then read back each register except endpoint 3's count, plus two unmapped addresses
module uoy_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import uoy_pkg::*;
	typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} uoy_row_type;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest, bm_req, bm_done, bm_resp, bm_nak, seen;
	logic [6:0] avs_address, bm_buf_size;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [1:0] bm_req_ep, bm_done_ep;
	logic [10:0] bm_start_addr;
	logic [7:0] r;
	uoy_count_type bm_done_len;
	int fail_count, checked, cyc;
	uoy_row_type rows[10];
	uoy_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bm_req(bm_req),
		.bm_req_ep(bm_req_ep), .bm_resp(bm_resp), .bm_nak(bm_nak), .bm_start_addr(bm_start_addr),
		.bm_buf_size(bm_buf_size), .bm_done(bm_done), .bm_done_ep(bm_done_ep), .bm_done_len(bm_done_len));
	uoy_bm_model bm_u (.clk(clk), .bm_resp(bm_resp), .bm_req(bm_req), .bm_req_ep(bm_req_ep),
		.bm_done(bm_done), .bm_done_ep(bm_done_ep), .bm_done_len(bm_done_len));
	task summarize;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task bus(input logic wr, input logic [6:0] a, input logic [7:0] w);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= {24'h000000, w};
		// hold until waitrequest is sampled low; only the bench timeout ends the wait
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task rst;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("waitrequest", 1, avs_waitrequest);
		chk("start in reset", 0, bm_start_addr);
		chk("resp in reset", 0, bm_resp);
		rst_n <= 1'b1;
	endtask : rst
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} <= '0;
		avs_byteenable <= 4'h1;
		rows = '{'{7'h14, 8'ha5, 8'ha5}, '{7'h18, 8'h40, 8'h40}, '{7'h1c, 8'hc0, 8'h40},
			'{7'h34, 8'h3c, 8'h3c}, '{7'h38, 8'h05, 8'h05}, '{7'h3c, 8'h08, 8'h08},
			'{7'h54, 8'hff, 8'hff}, '{7'h5c, 8'h40, 8'h40}, '{7'h74, 8'h5a, 8'h00}, '{7'h15, 8'h11, 8'h00}};
		rst();
		foreach (rows[i]) begin
			bus(1, rows[i].a, rows[i].w);
			bus(0, rows[i].a, 8'h00);
			chk("register", rows[i].e, r);
		end
		bm_u.token(2'h1, seen);
		chk("resp", 1, seen);
		chk("nak", 0, bm_nak);
		chk("start", {8'ha5, 3'h0}, bm_start_addr);
		chk("size", 7'h40, bm_buf_size);
		bm_u.store(2'h1, 7'h40);
		bus(0, 7'h18, 8'h00);
		chk("count", 8'hc0, r);
		bm_u.token(2'h1, seen);
		chk("resp", 1, seen);
		chk("nak", 1, bm_nak);
		chk("start", {8'ha5, 3'h0}, bm_start_addr);
		bm_u.token(2'h3, seen);
		chk("start", {8'hff, 3'h0}, bm_start_addr);
		chk("size", 7'h40, bm_buf_size);
		bm_u.token(2'h0, seen);
		chk("resp", 0, seen);
		chk("start", {8'hff, 3'h0}, bm_start_addr);
		avs_byteenable <= 4'h0;
		bus(1, 7'h18, 8'h00);
		avs_byteenable <= 4'h1;
		bus(0, 7'h18, 8'h00);
		chk("count", 8'hc0, r);
		// completion and firmware write land on one edge: the completion wins
		fork
			begin
				@(posedge clk);
				bm_u.store(2'h2, 7'h21);
			end
			bus(1, 7'h38, 8'h00);
		join
		bus(0, 7'h38, 8'h00);
		chk("count race", 8'ha1, r);
		bus(1, 7'h18, 8'h00);
		bm_u.token(2'h1, seen);
		chk("nak", 0, bm_nak);
		rst();
		bus(0, 7'h14, 8'h00);
		chk("base", 8'h00, r);
		bus(0, 7'h38, 8'h00);
		chk("count after reset", 8'h00, r);
		summarize();
	end
endmodule : uoy_top_tb
